// file: hdl/vrs_pkg.sv
// Package of constants and carrier types for the voltage reference sequencer
// Overview of operation
// R1: Fixed mode straps 00,01,10,11 select 1.4, 1.2, 1.0, 0.8 V targets.
// R2: After enable, soft-start ramps all plane references at about 2 mV per us.
// R3: Power-good rises only after soft-start ends and every plane is in regulation.
// R4: Host raises power-ok only after power-good is high.
// R5: While power-ok is high, watch the link for set-voltage commands.
// R6: Decode addressed planes and code; step each addressed plane to it.
// R7: A core plane commanded off leaves power-good asserted.
// R8: Host never turns the bridge plane off while a core plane is off.
// R9: Power-ok low steps planes back to held start-up code, link ignored.
// R10: After power-ok returns, wait for a fresh command before any change.
// R11: Enable low tri-states drivers, drops power-good, clears held code.
// R12: Power-on reset shuts regulators, drops power-good, discards held code.
// R13: Upward transitions step at a typical 7.5 mV per us.
// R14: Downward transitions step at 7.5 mV per us with forced continuous conduction; the code does not force it when the target is an off code (7c..7f).
// R15: Reference slew never exceeds 10 mV per us either way.
// R16: Power-good is unchanged during on-the-fly transitions.
// R17: Host is sole master and drives the link clock; device only receives.
// R18: Link timing follows high-speed I2C conventions.
// R19: Code 0 is 1.55 V, minus 12.5 mV per step; codes 7c..7f mean off.
// R20: Address byte bits 6:4 are 110b; bits 2,1,0 select core B, core A, bridge.
// R21: Data byte bit 7 is low-load hint, bits 6:0 the voltage code.
// R22: Acknowledge valid address and data bytes; start transition after stop.
// R23: Outside fixed mode, straps 00..11 latch 1.1, 1.0, 0.9, 0.8 V at enable.
// R24: Ramps advance one code step per fixed interval from the internal clock.
// R25: Ignore commands while power-ok is low or power-good still low.
package vrs_pkg;
    localparam int CODE_W = 7;
    localparam int PLANES = 3;
    // Plane index: bridge, core A, core B
    localparam int PL_BRIDGE = 0;
    localparam int PL_CORE_A = 1;
    localparam int PL_CORE_B = 2;
    // Voltage code map: 1.55 V at 0, 12.5 mV per step
    localparam int STEP_UV = 12500;
    localparam logic [6:0] CODE_OFF_MIN = 7'h7c;
    localparam logic [6:0] CODE_FIX_00 = 7'h0c;
    localparam logic [6:0] CODE_FIX_01 = 7'h1c;
    localparam logic [6:0] CODE_FIX_10 = 7'h2c;
    localparam logic [6:0] CODE_FIX_11 = 7'h3c;
    localparam logic [6:0] CODE_BOOT_00 = 7'h24;
    localparam logic [6:0] CODE_BOOT_01 = 7'h2c;
    localparam logic [6:0] CODE_BOOT_10 = 7'h34;
    localparam logic [6:0] CODE_BOOT_11 = 7'h3c;
    // Slew rates in microvolts per microsecond
    localparam int SOFT_UV_PER_US = 2000;
    localparam int OTF_UV_PER_US = 7500;
    localparam int MAX_UV_PER_US = 10000;
    localparam int CLK_MHZ = 100;
    // Cycles per code step; slower than or equal to the rate (rounded up)
    localparam int SOFT_STEP_CYC = (STEP_UV * CLK_MHZ + SOFT_UV_PER_US - 1) / SOFT_UV_PER_US;
    localparam int OTF_STEP_CYC = (STEP_UV * CLK_MHZ + OTF_UV_PER_US - 1) / OTF_UV_PER_US;
    localparam int MIN_STEP_CYC = (STEP_UV * CLK_MHZ + MAX_UV_PER_US - 1) / MAX_UV_PER_US;
    // Link address byte layout
    localparam logic [2:0] ADDR_TAG = 3'h6;
    localparam int ADDR_TAG_LSB = 4;
    localparam int DATA_HINT_BIT = 7;

    // Command carried from the link domain
    typedef struct packed {
        logic [PLANES-1:0] planes;
        logic low_load_hint;
        logic [CODE_W-1:0] voltage_code;
    } vrs_cmd_s;
endpackage

// file: hdl/vrs_stepper.sv
// One plane reference stepper: walks a code toward a target at a set interval
`timescale 1ns/10ps
module vrs_stepper #(
    parameter int CODE_W = 7,
    parameter int CNT_W = 10
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic clear,
    input wire logic [CODE_W-1:0] target,
    input wire logic [CNT_W-1:0] interval,
    output logic [CODE_W-1:0] code,
    output logic busy
);
    logic [CNT_W-1:0] tick_q;
    logic [CODE_W-1:0] code_q;

    initial
    begin
        if (CODE_W < 1 || CNT_W < 2)
            $error("vrs_stepper widths too small");
    end

    // Interval timer; one code step when it expires
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            tick_q <= '0;
        else if (ce)
        begin
            if (clear || code_q == target || tick_q >= interval - 1'b1)
                tick_q <= '0;
            else
                tick_q <= tick_q + 1'b1;
        end
    end

    // Larger code is a lower voltage
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            code_q <= '1;
        else if (ce)
        begin
            if (clear)
                code_q <= '1;
            else if (code_q != target && tick_q >= interval - 1'b1)
                code_q <= (target > code_q) ? code_q + 1'b1 : code_q - 1'b1; // R24
        end
    end

    assign code = code_q;
    assign busy = (code_q != target);
endmodule

// file: hdl/vrs_link_rx.sv
// Link-clock-domain receiver for the two-wire voltage command link
`timescale 1ns/10ps
module vrs_link_rx (
    input wire logic link_clk,
    input wire logic link_resetn,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output vrs_pkg::vrs_cmd_s cmd,
    output logic cmd_valid
);
    // Bit counter, shift register and byte phase on the link clock
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic phase_q;
    logic addr_ok_q;
    logic data_ok_q;
    vrs_pkg::vrs_cmd_s cmd_q;
    logic ack_q;

    // Shift on rising clock edges; ninth bit is acknowledge slot; held in reset outside frames
    always_ff @(posedge link_clk or negedge link_resetn)
    begin
        if (!link_resetn)
        begin
            bit_q <= '0;
            shift_q <= '0;
            phase_q <= 1'b0;
            addr_ok_q <= 1'b0;
            data_ok_q <= 1'b0;
            cmd_q <= '0;
        end
        else if (bit_q == 4'h8)
        begin
            bit_q <= 4'h0;
            if (!phase_q && shift_q[7:5] == vrs_pkg::ADDR_TAG && !shift_q[0]) // R20
            begin
                addr_ok_q <= 1'b1;
                cmd_q.planes <= shift_q[3:1];
                phase_q <= 1'b1;
            end
            else if (phase_q && addr_ok_q)
            begin
                data_ok_q <= 1'b1; // R21
                cmd_q.low_load_hint <= shift_q[vrs_pkg::DATA_HINT_BIT];
                cmd_q.voltage_code <= shift_q[6:0];
            end
        end
        else
        begin
            bit_q <= bit_q + 1'b1;
            shift_q <= {shift_q[6:0], sda_i};
        end
    end

    // Acknowledge driven low during the ninth clock after a valid byte
    always_ff @(negedge link_clk or negedge link_resetn)
    begin
        if (!link_resetn)
            ack_q <= 1'b0;
        else
            ack_q <= (bit_q == 4'h8) && (phase_q ? addr_ok_q :
                (shift_q[7:5] == vrs_pkg::ADDR_TAG && !shift_q[0])); // R22
    end

    assign sda_o = 1'b0; // R17
    assign sda_oe = ack_q;
    assign cmd = cmd_q;
    assign cmd_valid = data_ok_q;
endmodule

// file: hdl/vrs_sequencer.sv
// Top of the voltage reference sequencer: start-up, soft-start, commands, power-good
`timescale 1ns/10ps
module vrs_sequencer #(
    parameter int CNT_W = 10
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic enable,
    input wire logic fixed_voltage_mode,
    input wire logic cpu_power_ok_input,
    input wire logic planes_in_regulation,
    input wire logic serial_clock_line,
    input wire logic vid_link_data_line_i,
    output logic vid_link_data_line_o,
    output logic vid_link_data_line_oe,
    output logic power_good_output,
    output logic drivers_enabled,
    output logic force_ccm,
    output logic low_load_hint,
    output logic [6:0] code_bridge_plane,
    output logic [6:0] code_core_plane_a,
    output logic [6:0] code_core_plane_b
);
    typedef enum logic [2:0] {ST_OFF, ST_SOFT, ST_BOOT_RUN, ST_CMD_RUN, ST_RETURN} vrs_state_e;

    localparam logic [CNT_W-1:0] SOFT_IV = CNT_W'(vrs_pkg::SOFT_STEP_CYC);
    localparam logic [CNT_W-1:0] OTF_IV = CNT_W'(vrs_pkg::OTF_STEP_CYC);

    initial
    begin
        if (vrs_pkg::SOFT_STEP_CYC >= (1 << CNT_W) || vrs_pkg::OTF_STEP_CYC < vrs_pkg::MIN_STEP_CYC)
            $error("vrs_sequencer step interval does not fit");
    end

    vrs_state_e state_q;
    vrs_state_e state_d;
    logic [2:0] en_sync_q;
    logic [2:0] pok_sync_q;
    logic [2:0] scl_sync_q;
    logic [2:0] sda_sync_q;
    logic [2:0] tgl_sync_q;
    logic en_prev_q;
    logic [6:0] hold_code_q;
    logic hold_valid_q;
    logic [6:0] target_q [vrs_pkg::PLANES];
    logic [6:0] code_w [vrs_pkg::PLANES];
    logic [vrs_pkg::PLANES-1:0] busy_w;
    logic [CNT_W-1:0] iv_q;
    logic power_good_output_q;
    logic drv_q;
    logic ccm_q;
    logic hint_q;
    logic [6:0] out_q [vrs_pkg::PLANES];
    logic start_w;
    logic stop_w;
    logic link_resetn;
    logic link_sda_o;
    logic link_sda_oe;
    logic sda_o_q;
    vrs_pkg::vrs_cmd_s cmd_w;
    logic cmd_vld_w;
    logic any_busy;
    logic cmd_evt;
    logic en_s;
    logic pok_s;
    logic [6:0] strap_code;

    // Three-stage synchronisers; for enable, power-ok and command valid, second and third stages must agree
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            en_sync_q <= '0;
            pok_sync_q <= '0;
            scl_sync_q <= '1;
            sda_sync_q <= '1;
            tgl_sync_q <= '0;
        end
        else if (ce)
        begin
            en_sync_q <= {en_sync_q[1:0], enable};
            pok_sync_q <= {pok_sync_q[1:0], cpu_power_ok_input};
            scl_sync_q <= {scl_sync_q[1:0], serial_clock_line};
            sda_sync_q <= {sda_sync_q[1:0], vid_link_data_line_i};
            tgl_sync_q <= {tgl_sync_q[1:0], cmd_vld_w};
        end
    end

    // Filtered levels held until stages two and three agree
    logic en_f_q;
    logic pok_f_q;
    logic tgl_f_q;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            en_f_q <= 1'b0;
            pok_f_q <= 1'b0;
            tgl_f_q <= 1'b0;
        end
        else if (ce)
        begin
            if (en_sync_q[1] == en_sync_q[2])
                en_f_q <= en_sync_q[2];
            if (pok_sync_q[1] == pok_sync_q[2])
                pok_f_q <= pok_sync_q[2];
            if (tgl_sync_q[1] == tgl_sync_q[2])
                tgl_f_q <= tgl_sync_q[2];
        end
    end
    assign en_s = en_f_q;
    assign pok_s = pok_f_q;

    // Command taken at the stop of a frame whose data byte was good; valid is settled by then
    assign cmd_evt = stop_w && in_frame_q && tgl_f_q && pok_s && power_good_output_q; // R25 R5 R10 R22

    // Start-up code from the straps, fixed or boot table
    always_comb
    begin
        case ({sda_sync_q[2], scl_sync_q[2]} == 2'b00 ? 2'b00 : {scl_sync_q[2], sda_sync_q[2]})
            2'b00: strap_code = fixed_voltage_mode ? vrs_pkg::CODE_FIX_00 : vrs_pkg::CODE_BOOT_00; // R1 R23
            2'b01: strap_code = fixed_voltage_mode ? vrs_pkg::CODE_FIX_01 : vrs_pkg::CODE_BOOT_01;
            2'b10: strap_code = fixed_voltage_mode ? vrs_pkg::CODE_FIX_10 : vrs_pkg::CODE_BOOT_10;
            default: strap_code = fixed_voltage_mode ? vrs_pkg::CODE_FIX_11 : vrs_pkg::CODE_BOOT_11;
        endcase
    end

    // Hold register latched at enable rise, cleared by enable low or reset
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hold_code_q <= '1; // R12
            hold_valid_q <= 1'b0;
            en_prev_q <= 1'b0;
        end
        else if (ce)
        begin
            en_prev_q <= en_s;
            if (!en_s)
            begin
                hold_code_q <= '1; // R11
                hold_valid_q <= 1'b0;
            end
            else if (!en_prev_q)
            begin
                hold_code_q <= strap_code; // R23
                hold_valid_q <= 1'b1;
            end
        end
    end

    // Sequencer state machine
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_OFF:
                if (en_s && hold_valid_q)
                    state_d = ST_SOFT;
            ST_SOFT:
                if (!any_busy && planes_in_regulation)
                    state_d = ST_BOOT_RUN; // R3
            ST_BOOT_RUN:
                if (cmd_evt)
                    state_d = ST_CMD_RUN;
            ST_CMD_RUN:
                if (!pok_s)
                    state_d = ST_RETURN; // R9
            ST_RETURN:
                if (cmd_evt)
                    state_d = ST_CMD_RUN; // R10
            default:
                state_d = ST_OFF;
        endcase
        if (!en_s)
            state_d = ST_OFF; // R11
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state_q <= ST_OFF;
        else if (ce)
            state_q <= state_d;
    end

    // Per-plane targets
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < vrs_pkg::PLANES; i++)
                target_q[i] <= '1;
            hint_q <= 1'b1;
        end
        else if (ce)
        begin
            for (int i = 0; i < vrs_pkg::PLANES; i++)
            begin
                if (state_d == ST_OFF)
                    target_q[i] <= '1;
                else if (state_q == ST_OFF || (state_d == ST_RETURN && state_q != ST_RETURN))
                    target_q[i] <= hold_code_q; // R2 R9
                else if (cmd_evt && cmd_w.planes[i])
                    target_q[i] <= cmd_w.voltage_code; // R6
            end
            if (cmd_evt)
                hint_q <= cmd_w.low_load_hint;
        end
    end

    // Soft-start rate before power-good, command rate after
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            iv_q <= SOFT_IV;
        else if (ce)
            iv_q <= (state_q == ST_SOFT || state_q == ST_OFF) ? SOFT_IV : OTF_IV; // R2 R13 R15
    end

    // One stepper per plane
    genvar g;
    generate
        for (g = 0; g < vrs_pkg::PLANES; g++)
        begin : gen_plane
            vrs_stepper #(.CODE_W(vrs_pkg::CODE_W), .CNT_W(CNT_W)) u_step (
                .clk(clk),
                .resetn(resetn),
                .ce(ce),
                .clear(state_q == ST_OFF),
                .target(target_q[g]),
                .interval(iv_q),
                .code(code_w[g]),
                .busy(busy_w[g])
            );
        end
    endgenerate
    assign any_busy = |busy_w;

    // Registered plant outputs
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            power_good_output_q <= 1'b0;
            drv_q <= 1'b0;
            ccm_q <= 1'b0;
            for (int i = 0; i < vrs_pkg::PLANES; i++)
                out_q[i] <= '1;
        end
        else if (ce)
        begin
            drv_q <= (state_d != ST_OFF); // R11 R12
            if (state_d == ST_OFF)
                power_good_output_q <= 1'b0; // R11 R12
            else if (state_q == ST_SOFT && state_d == ST_BOOT_RUN)
                power_good_output_q <= 1'b1; // R3 R7 R16
            ccm_q <= 1'b0;
            for (int i = 0; i < vrs_pkg::PLANES; i++)
            begin
                out_q[i] <= code_w[i]; // R19
                if (code_w[i] < target_q[i] && target_q[i] < vrs_pkg::CODE_OFF_MIN)
                    ccm_q <= 1'b1; // R14
            end
        end
    end

    // Start and stop detection on the system clock; link reset outside frames
    logic scl_prev_q;
    logic sda_prev_q;
    logic in_frame_q;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            in_frame_q <= 1'b0;
        end
        else if (ce)
        begin
            scl_prev_q <= scl_sync_q[2];
            sda_prev_q <= sda_sync_q[2];
            if (start_w && pok_s && power_good_output_q)
                in_frame_q <= 1'b1; // R18
            else if (stop_w || !pok_s)
                in_frame_q <= 1'b0;
        end
    end
    assign start_w = scl_sync_q[2] && sda_prev_q && !sda_sync_q[2];
    assign stop_w = scl_sync_q[2] && !sda_prev_q && sda_sync_q[2];
    assign link_resetn = resetn && in_frame_q;

    // Receiver clocked by the host-driven link clock
    vrs_link_rx u_rx (
        .link_clk(serial_clock_line),
        .link_resetn(link_resetn),
        .sda_i(vid_link_data_line_i),
        .sda_o(link_sda_o),
        .sda_oe(link_sda_oe),
        .cmd(cmd_w),
        .cmd_valid(cmd_vld_w)
    );

    // Open-drain level held in a flop; enable comes straight from the link domain flop
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            sda_o_q <= 1'b0;
        else if (ce)
            sda_o_q <= link_sda_o;
    end

    assign vid_link_data_line_o = sda_o_q;
    assign vid_link_data_line_oe = link_sda_oe;
    assign power_good_output = power_good_output_q;
    assign drivers_enabled = drv_q;
    assign force_ccm = ccm_q;
    assign low_load_hint = hint_q;
    assign code_bridge_plane = out_q[vrs_pkg::PL_BRIDGE];
    assign code_core_plane_a = out_q[vrs_pkg::PL_CORE_A];
    assign code_core_plane_b = out_q[vrs_pkg::PL_CORE_B];
endmodule

// file: test/vrs_sequencer_monitor.sv
// Port checker for the voltage reference sequencer
`timescale 1ns/10ps
module vrs_sequencer_monitor #(
    parameter int CNT_W = 10
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic enable,
    input wire logic fixed_voltage_mode,
    input wire logic cpu_power_ok_input,
    input wire logic planes_in_regulation,
    input wire logic serial_clock_line,
    input wire logic vid_link_data_line_i,
    input wire logic vid_link_data_line_o,
    input wire logic vid_link_data_line_oe,
    input wire logic power_good_output,
    input wire logic drivers_enabled,
    input wire logic force_ccm,
    input wire logic low_load_hint,
    input wire logic [6:0] code_bridge_plane,
    input wire logic [6:0] code_core_plane_a,
    input wire logic [6:0] code_core_plane_b
);
    localparam int MIN_GAP = vrs_pkg::MIN_STEP_CYC;
    logic [11:0] gap_q;
    logic [6:0] last_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Cycles since core A last moved; parked high while drivers are off
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            gap_q <= 12'hfff;
            last_q <= 7'h7f;
        end
        else
        begin
            last_q <= code_core_plane_a;
            if (!drivers_enabled)
                gap_q <= 12'hfff;
            else if (code_core_plane_a != last_q)
                gap_q <= 12'h001;
            else if (gap_q != 12'hfff)
                gap_q <= gap_q + 12'h001;
        end
    end
    property p_pg_drv;
        power_good_output |-> drivers_enabled;
    endproperty
    a_pg_drv: assert property (p_pg_drv)
        else $error("power good while drivers off");
    property p_en_drop;
        $fell(enable) |-> ##[1:8] (!power_good_output && !drivers_enabled);
    endproperty
    a_en_drop: assert property (p_en_drop)
        else $error("enable loss not honoured");
    property p_en_low;
        !enable [*8] |-> !drivers_enabled;
    endproperty
    a_en_low: assert property (p_en_low)
        else $error("drivers on while disabled");
    property p_gap;
        code_core_plane_a != last_q && drivers_enabled && enable |-> gap_q >= MIN_GAP;
    endproperty
    a_gap: assert property (p_gap)
        else $error("reference slew too fast");
    property p_pg_hold;
        power_good_output && enable |=> power_good_output;
    endproperty
    a_pg_hold: assert property (p_pg_hold)
        else $error("power good dropped while enabled");
    property p_ccm;
        code_core_plane_a > last_q && drivers_enabled && enable |-> force_ccm || $past(force_ccm);
    endproperty
    a_ccm: assert property (p_ccm)
        else $error("descent without forced conduction");
    property p_od;
        vid_link_data_line_oe |-> !vid_link_data_line_o;
    endproperty
    a_od: assert property (p_od)
        else $error("data line driven high");
    property p_rst;
        $rose(resetn) |-> !power_good_output && code_bridge_plane == 7'h7f;
    endproperty
    a_rst: assert property (p_rst)
        else $error("state kept over reset");
    c_pg: cover property ($rose(power_good_output));
    c_ccm: cover property ($rose(force_ccm));
    c_ack: cover property ($rose(vid_link_data_line_oe));
endmodule

bind vrs_sequencer vrs_sequencer_monitor #(.CNT_W(CNT_W)) mon_u (.clk(clk), .resetn(resetn),
    .ce(ce), .enable(enable), .fixed_voltage_mode(fixed_voltage_mode),
    .cpu_power_ok_input(cpu_power_ok_input), .planes_in_regulation(planes_in_regulation),
    .serial_clock_line(serial_clock_line), .vid_link_data_line_i(vid_link_data_line_i),
    .vid_link_data_line_o(vid_link_data_line_o), .vid_link_data_line_oe(vid_link_data_line_oe),
    .power_good_output(power_good_output), .drivers_enabled(drivers_enabled),
    .force_ccm(force_ccm), .low_load_hint(low_load_hint), .code_bridge_plane(code_bridge_plane),
    .code_core_plane_a(code_core_plane_a), .code_core_plane_b(code_core_plane_b));

// file: test/vrs_host_model.sv
// Host link master model: strap levels, send-byte frames, ack sampling
`timescale 1ns/10ps
module vrs_host_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    localparam time HALF = 80ns;
    // Clock stands high between frames, data released to the pull-up
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Strap levels seen at enable
    task automatic strap(input logic c, input logic d);
        scl = c;
        sda_low = ~d;
    endtask
    // One byte MSB first; ninth clock samples the slave ack
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            #(HALF/2) sda_low = ~b[i];
            #(HALF/2) scl = 1'b1;
            #(HALF) scl = 1'b0;
        end
        #(HALF/2) sda_low = 1'b0;
        #(HALF/2) scl = 1'b1;
        #(HALF) ack = ~sda;
        scl = 1'b0;
    endtask
    // Start, address, data, stop; host alone drives the clock
    task automatic frame(input logic [7:0] a, input logic [7:0] d, output logic [1:0] acks);
        #(HALF) sda_low = 1'b1;
        #(HALF) scl = 1'b0;
        put_byte(a, acks[1]);
        put_byte(d, acks[0]);
        #(HALF/2) sda_low = 1'b1;
        #(HALF/2) scl = 1'b1;
        #(HALF) sda_low = 1'b0;
        #(HALF);
    endtask
endmodule

// file: test/vrs_sequencer_tb.sv
// Self-checking bench for the voltage reference sequencer
`timescale 1ns/10ps
module vrs_sequencer_tb;
    localparam int SOFT = vrs_pkg::SOFT_STEP_CYC;
    localparam int OTF = vrs_pkg::OTF_STEP_CYC;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic enable = 1'b0;
    logic fvm = 1'b0;
    logic pok = 1'b0;
    logic pir = 1'b0;
    logic scl, sda_low, oe, pg, drv, ccm, hint;
    logic [6:0] cb, ca, cc;
    logic [1:0] acks;
    wire sda = ~(sda_low | oe);
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;
    vrs_sequencer dut_u (.clk(clk), .resetn(resetn), .ce(1'b1), .enable(enable),
        .fixed_voltage_mode(fvm), .cpu_power_ok_input(pok), .planes_in_regulation(pir),
        .serial_clock_line(scl), .vid_link_data_line_i(sda), .vid_link_data_line_o(),
        .vid_link_data_line_oe(oe), .power_good_output(pg), .drivers_enabled(drv),
        .force_ccm(ccm), .low_load_hint(hint), .code_bridge_plane(cb),
        .code_core_plane_a(ca), .code_core_plane_b(cc));
    vrs_host_model host_u (.scl(scl), .sda_low(sda_low), .sda(sda));
    // System clock
    always #5 clk = ~clk;
    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 120000)
        begin
            err_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_a(input logic [6:0] e, input int lim);
        for (int n = 0; n < lim && ca !== e; n++)
            @(negedge clk);
    endtask
    task automatic step_time(output int n);
        logic [6:0] v;
        v = ca;
        for (n = 0; n < 4000 && ca === v; n++)
            @(negedge clk);
    endtask
    task automatic t_start(input logic f, input logic c, input logic d, input logic [6:0] e);
        int n;
        int s;
        s = 127 - int'(e);
        fvm = f;
        host_u.strap(c, d);
        repeat (20) @(negedge clk);
        enable = 1'b1;
        repeat (20) @(negedge clk);
        host_u.strap(1'b1, 1'b1);
        for (n = 20; n < s * SOFT * 2 && ca !== e; n++)
            @(negedge clk);
        chk({1'b0, ca}, {1'b0, e});
        chk(8'(n >= s * SOFT * 9 / 10 && n <= s * SOFT * 11 / 10 + 100), 8'h01);
        repeat (50) @(negedge clk);
        chk({1'b0, cb}, {1'b0, e});
        chk(8'(pg), 8'h00);
        pir = 1'b1;
        repeat (100) @(negedge clk);
        chk(8'(pg), 8'h01);
    endtask
    task automatic t_up();
        int n;
        pok = 1'b1;
        host_u.frame(8'hc4, 8'h30, acks);
        chk(8'(acks), 8'h03);
        step_time(n);
        step_time(n);
        chk(8'(n >= OTF * 9 / 10 && n <= OTF * 11 / 10), 8'h01);
        wait_a(7'h30, OTF * 8);
        chk({ca, cb}, {7'h30, 7'h34});
        chk({hint, cc}, {1'b0, 7'h34});
        chk(8'(pg), 8'h01);
    endtask
    task automatic t_pok();
        @(negedge clk) pok = 1'b0;
        host_u.frame(8'hc4, 8'h20, acks);
        wait_a(7'h34, OTF * 10);
        repeat (600) @(negedge clk);
        chk({1'b0, ca}, 8'h34);
        pok = 1'b1;
        repeat (600) @(negedge clk);
        chk({1'b0, ca}, 8'h34);
    endtask
    task automatic t_bad();
        host_u.frame(8'ha4, 8'h20, acks);
        chk(8'(acks[1]), 8'h00);
        host_u.frame(8'hc5, 8'h20, acks);
        repeat (600) @(negedge clk);
        chk({1'b0, ca}, 8'h34);
    endtask
    task automatic t_multi();
        host_u.frame(8'hce, 8'hb6, acks);
        for (int n = 0; n < 500 && ccm !== 1'b1; n++)
            @(negedge clk);
        chk(8'(ccm), 8'h01);
        wait_a(7'h36, OTF * 6);
        repeat (OTF * 2) @(negedge clk);
        chk({cb, cc}, {7'h36, 7'h36});
        chk({hint, ca}, 8'hb6);
        chk(8'({pg, ccm}), 8'h02);
    endtask
    task automatic t_en_off();
        @(negedge clk) pok = 1'b0;
        enable = 1'b0;
        pir = 1'b0;
        repeat (10) @(negedge clk);
        chk(8'({pg, drv}), 8'h00);
    endtask
    task automatic t_off();
        pok = 1'b1;
        host_u.frame(8'hc8, 8'h7c, acks);
        for (int n = 0; n < 64 * OTF * 2 && cc !== 7'h7c; n++)
            @(negedge clk);
        chk({1'b0, cc}, 8'h7c);
        chk({pg, cb}, {1'b1, 7'h3c});
    endtask
    task automatic t_reset();
        @(negedge clk) resetn = 1'b0;
        #2;
        chk({pg, cb}, 8'h7f);
        chk(8'(drv), 8'h00);
        repeat (16) @(negedge clk);
        resetn = 1'b1;
    endtask
    // Main sequence
    initial
    begin
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        t_start(1'b0, 1'b1, 1'b0, 7'h34);
        t_up();
        t_pok();
        t_bad();
        t_multi();
        t_en_off();
        t_start(1'b1, 1'b1, 1'b1, 7'h3c);
        t_off();
        t_reset();
        print_verdict();
    end
endmodule
